// File: core/charge_seq_pkg.sv
package charge_seq_pkg;

	// Clock and timing figures; each cycle count derives from its time in seconds.
	localparam longint CLK_HZ             = 64'd125_000_000;
	localparam longint PRECHARGE_TIME_S   = 64'd1800;
	localparam longint FAST_CHARGE_TIME_S = 64'd18000;
	localparam longint TAPER_TIME_S       = 64'd1800;
	localparam longint PRECHARGE_CYCLES   = PRECHARGE_TIME_S * CLK_HZ;
	localparam longint FAST_CHARGE_CYCLES = FAST_CHARGE_TIME_S * CLK_HZ;
	localparam longint TAPER_CYCLES       = TAPER_TIME_S * CLK_HZ;
	localparam int     TIMER_W            = 42;

	// Register map, byte addresses of aligned words.
	localparam logic [7:0] ADDR_CTRL   = 8'h00;
	localparam logic [7:0] ADDR_STATUS = 8'h04;

	// Control register fields.
	localparam int CTRL_INHIBIT_BIT = 0;
	localparam logic CTRL_RESET = 1'b0;

	// Status register fields.
	localparam int STAT_STATE_LSB  = 0;
	localparam int STAT_SOURCE_BIT = 4;
	localparam int STAT_CHARGE_BIT = 5;
	localparam int STAT_RATE_BIT   = 6;
	localparam int STAT_AC_BIT     = 7;
	localparam int STAT_USB_BIT    = 8;

	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
	localparam logic [1:0] HRESP_OKAY    = 2'h0;

	typedef enum logic [2:0] {
		ST_SLEEP     = 3'b000,
		ST_DISABLED  = 3'b001,
		ST_PRECHARGE = 3'b010,
		ST_FAST      = 3'b011,
		ST_REGULATE  = 3'b100,
		ST_DONE      = 3'b101,
		ST_FAULT     = 3'b110
	} charge_state_e;

	// Pin levels; the rate select high-impedance flag comes from a window detector.
	typedef struct packed {
		logic ac_present;
		logic usb_present;
		logic charge_enable_n;
		logic usb_rate_select;
		logic usb_rate_hiz;
	} pin_s;

	// Comparator decisions from the analogue front end.
	typedef struct packed {
		logic below_precharge_exit;
		logic at_regulation_voltage;
		logic below_taper;
		logic below_cutoff;
		logic below_recharge;
	} sense_s;

endpackage : charge_seq_pkg

// File: core/level_sync.sv
`timescale 1ns/1ns
module level_sync #(
	parameter int W = 1
) (
	input  wire logic         hclk,    // System clock.
	input  wire logic         hresetn, // Asynchronous reset, active low.
	input  wire logic [W-1:0] d,       // Asynchronous levels.
	output logic      [W-1:0] q        // Levels in the clock domain.
);

	logic [W-1:0] meta;
	logic [W-1:0] next_meta;
	logic [W-1:0] next_q;

	always_comb begin
		next_meta = d;
		next_q    = meta;
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			meta <= '0;
			q    <= '0;
		end else begin
			meta <= next_meta;
			q    <= next_q;
		end
	end

endmodule : level_sync

// File: core/charge_sequence_controller.sv
`timescale 1ns/1ns
// Summary of operation
// [R1] Charge from AC by default, USB otherwise.
// [R2] AC wins when both inputs present.
// [R3] Below precharge exit, command precharge current.
// [R4] Precharge timer expiry without exit gives fault.
// [R5] Host selects USB rate low/high.
// [R6] High-impedance rate select disables USB charging.
// [R7] Regulation voltage reached enters voltage regulation.
// [R8] Fast timer expiry before taper gives fault.
// [R9] Taper reached starts hold timer, then terminate.
// [R10] Current back above taper resets hold timer.
// [R11] Below cutoff current terminates at once.
// [R12] After termination, recharge below recharge threshold.
// [R13] Both inputs absent enters sleep.
// [R14] Status lines encode precharge/fast/done/fault/sleep.
// [R15] Power-good on while valid AC present.
// [R16] Power-good off in sleep.
// [R17] System avoids converter use during precharge.
// [R18] Enable high disables; falling edge resets timers.
// [R19] Fault clears below recharge threshold, or reset.
// [R20] Comparators synchronised; timers count the clock.
//
module charge_sequence_controller
	import charge_seq_pkg::*;
#(
	parameter longint PRECHARGE_LIMIT = PRECHARGE_CYCLES,
	parameter longint FAST_LIMIT      = FAST_CHARGE_CYCLES,
	parameter longint TAPER_LIMIT     = TAPER_CYCLES
) (
	input  wire logic        hclk,              // System clock, 125 MHz.
	input  wire logic        hresetn,           // Asynchronous reset, active low.
	input  wire logic        hsel,              // AHB slave select.
	input  wire logic [31:0] haddr,             // AHB address.
	input  wire logic [1:0]  htrans,            // AHB transfer type.
	input  wire logic        hwrite,            // AHB write.
	input  wire logic [2:0]  hsize,             // AHB size, word only.
	input  wire logic [31:0] hwdata,            // AHB write data.
	input  wire logic        hready,            // AHB bus ready.
	output logic      [31:0] hrdata,            // AHB read data.
	output logic             hreadyout,         // AHB slave ready.
	output logic      [1:0]  hresp,             // AHB response.
	input  wire pin_s        pins,              // Asynchronous pin levels.
	input  wire sense_s      sense,             // Asynchronous comparator levels.
	output logic             charge_on,         // Charger power stage on.
	output logic             precharge_mode,    // Precharge current selected.
	output logic             usb_source,        // USB input selected.
	output logic             usb_high_rate,     // High USB current rate.
	output logic             status_line_a_out, // Open-drain data, always low.
	output logic             status_line_a_oe,  // Transistor on.
	output logic             status_line_b_out, // Open-drain data, always low.
	output logic             status_line_b_oe,  // Transistor on.
	output logic             adapter_good_n_out,// Open-drain data, always low.
	output logic             adapter_good_n_oe  // Transistor on.
);

	////////////////////////////////////////////////////////////////////////////////

	pin_s   pin_s_q;
	sense_s sense_q;

	level_sync #(.W($bits(pin_s))) u_pin_sync ( // R20
		.hclk(hclk), .hresetn(hresetn), .d(pins), .q(pin_s_q)
	);

	level_sync #(.W($bits(sense_s))) u_sense_sync ( // R20
		.hclk(hclk), .hresetn(hresetn), .d(sense), .q(sense_q)
	);

	////////////////////////////////////////////////////////////////////////////////

	logic                ctrl_inhibit;
	logic                next_ctrl_inhibit;
	logic                dp_write;
	logic                next_dp_write;
	logic [7:0]          dp_addr;
	logic [7:0]          next_dp_addr;
	logic [31:0]         next_hrdata;
	charge_state_e       state;
	charge_state_e       next_state;
	logic [TIMER_W-1:0]  safety_cnt;
	logic [TIMER_W-1:0]  next_safety_cnt;
	logic [TIMER_W-1:0]  taper_cnt;
	logic [TIMER_W-1:0]  next_taper_cnt;
	logic                ce_prev;
	logic                ce_fall;
	logic                source_ok;
	logic                run_ok;
	logic                next_charge_on;
	logic                next_precharge;
	logic                next_usb_source;
	logic                next_usb_high;
	logic                next_stat_a;
	logic                next_stat_b;
	logic                next_pg;

	function automatic logic [31:0] status_word(charge_state_e st, logic src,
		logic chg, logic rate, pin_s p);
		logic [31:0] w;
		w = '0;
		w[STAT_STATE_LSB +: 3] = st;
		w[STAT_SOURCE_BIT]     = src;
		w[STAT_CHARGE_BIT]     = chg;
		w[STAT_RATE_BIT]       = rate;
		w[STAT_AC_BIT]         = p.ac_present;
		w[STAT_USB_BIT]        = p.usb_present;
		return w;
	endfunction : status_word

	// Zero-wait slave: read data is prepared during the address phase so that
	// it comes from a flop in the data phase.
	always_comb begin
		next_dp_write     = 1'b0;
		next_dp_addr      = dp_addr;
		next_hrdata       = hrdata;
		next_ctrl_inhibit = ctrl_inhibit;
		if (dp_write && dp_addr == ADDR_CTRL) begin
			next_ctrl_inhibit = hwdata[CTRL_INHIBIT_BIT];
		end
		if (hsel && hready && htrans == HTRANS_NONSEQ) begin
			next_dp_write = hwrite;
			next_dp_addr  = haddr[7:0];
			if (!hwrite) begin
				case (haddr[7:0])
					ADDR_CTRL: begin
						next_hrdata = {31'h0, ctrl_inhibit};
					end
					ADDR_STATUS: begin
						next_hrdata = status_word(state, usb_source, charge_on,
							usb_high_rate, pin_s_q);
					end
					default: begin
						next_hrdata = 32'h0;
					end
				endcase
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ctrl_inhibit <= CTRL_RESET;
			dp_write     <= 1'b0;
			dp_addr      <= 8'h00;
			hrdata       <= 32'h0;
			hreadyout    <= 1'b1;
			hresp        <= HRESP_OKAY;
		end else begin
			ctrl_inhibit <= next_ctrl_inhibit;
			dp_write     <= next_dp_write;
			dp_addr      <= next_dp_addr;
			hrdata       <= next_hrdata;
			hreadyout    <= 1'b1;
			hresp        <= HRESP_OKAY;
		end
	end

	////////////////////////////////////////////////////////////////////////////////

	assign ce_fall   = ce_prev && !pin_s_q.charge_enable_n; // R18
	// AC is taken whenever present; USB only if its rate pin is not floating.
	assign source_ok = pin_s_q.ac_present ||
		(pin_s_q.usb_present && !pin_s_q.usb_rate_hiz); // R1 R2 R6
	assign run_ok    = source_ok && !pin_s_q.charge_enable_n && !ctrl_inhibit && !ce_fall;

	always_comb begin
		next_state      = state;
		next_safety_cnt = safety_cnt;
		next_taper_cnt  = taper_cnt;
		if (!pin_s_q.ac_present && !pin_s_q.usb_present) begin
			next_state = ST_SLEEP; // R13
		end else if (pin_s_q.charge_enable_n || ctrl_inhibit || !source_ok) begin
			next_state = ST_DISABLED; // R18 R6
		end else if (ce_fall || state == ST_SLEEP || state == ST_DISABLED) begin
			// A fresh cycle clears both timers and any fault.
			next_state      = sense_q.below_precharge_exit ? ST_PRECHARGE : ST_FAST; // R18 R3
			next_safety_cnt = '0;
			next_taper_cnt  = '0;
		end else begin
			case (state)
				ST_PRECHARGE: begin
					next_safety_cnt = safety_cnt + 1'b1;
					if (!sense_q.below_precharge_exit) begin
						next_state      = ST_FAST;
						next_safety_cnt = '0;
					end else if (safety_cnt == TIMER_W'(PRECHARGE_LIMIT - 1)) begin
						next_state = ST_FAULT; // R4
					end
				end
				ST_FAST: begin
					next_safety_cnt = safety_cnt + 1'b1;
					if (safety_cnt == TIMER_W'(FAST_LIMIT - 1)) begin
						next_state = ST_FAULT; // R8
					end else if (sense_q.at_regulation_voltage) begin
						next_state = ST_REGULATE; // R7
					end
				end
				ST_REGULATE: begin
					if (sense_q.below_cutoff) begin
						next_state = ST_DONE; // R11
					end else if (sense_q.below_taper) begin
						next_taper_cnt = taper_cnt + 1'b1; // R9
						if (taper_cnt == TIMER_W'(TAPER_LIMIT - 1)) begin
							next_state = ST_DONE; // R9
						end
					end else begin
						next_taper_cnt  = '0; // R10
						next_safety_cnt = safety_cnt + 1'b1;
						if (safety_cnt == TIMER_W'(FAST_LIMIT - 1)) begin
							next_state = ST_FAULT; // R8
						end
					end
				end
				ST_DONE, ST_FAULT: begin
					if (sense_q.below_recharge) begin
						next_state      = sense_q.below_precharge_exit ? ST_PRECHARGE
							: ST_FAST; // R12 R19
						next_safety_cnt = '0;
						next_taper_cnt  = '0;
					end
				end
				default: begin
					next_state = ST_DISABLED;
				end
			endcase
		end
	end

	// Charge and status outputs are decoded from the next state so that the flops match the state; usb_source and usb_high_rate come from the pins.
	always_comb begin
		next_charge_on  = next_state inside {ST_PRECHARGE, ST_FAST, ST_REGULATE};
		next_precharge  = next_state == ST_PRECHARGE; // R3
		next_usb_source = !pin_s_q.ac_present; // R1 R2
		next_usb_high   = !pin_s_q.ac_present && !pin_s_q.usb_rate_hiz
			&& pin_s_q.usb_rate_select; // R5 R6
		next_stat_a     = next_state inside {ST_PRECHARGE, ST_FAST, ST_REGULATE}; // R14
		next_stat_b     = next_state inside {ST_PRECHARGE, ST_DONE}; // R14
		next_pg         = pin_s_q.ac_present && next_state != ST_SLEEP; // R15 R16
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state              <= ST_SLEEP;
			safety_cnt         <= '0;
			taper_cnt          <= '0;
			ce_prev            <= 1'b0;
			charge_on          <= 1'b0;
			precharge_mode     <= 1'b0;
			usb_source         <= 1'b0;
			usb_high_rate      <= 1'b0;
			status_line_a_out  <= 1'b0;
			status_line_a_oe   <= 1'b0;
			status_line_b_out  <= 1'b0;
			status_line_b_oe   <= 1'b0;
			adapter_good_n_out <= 1'b0;
			adapter_good_n_oe  <= 1'b0;
		end else begin
			state              <= next_state;
			safety_cnt         <= next_safety_cnt;
			taper_cnt          <= next_taper_cnt;
			ce_prev            <= pin_s_q.charge_enable_n;
			charge_on          <= next_charge_on;
			precharge_mode     <= next_precharge;
			usb_source         <= next_usb_source;
			usb_high_rate      <= next_usb_high;
			status_line_a_out  <= 1'b0;
			status_line_a_oe   <= next_stat_a;
			status_line_b_out  <= 1'b0;
			status_line_b_oe   <= next_stat_b;
			adapter_good_n_out <= 1'b0;
			adapter_good_n_oe  <= next_pg;
		end
	end

	////////////////////////////////////////////////////////////////////////////////

	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	property p_ac_priority;
		charge_on && usb_source |-> !$past(pin_s_q.ac_present);
	endproperty
	a_ac_priority: assert property (p_ac_priority) else $error("USB used with AC present"); // R2
	property p_precharge_out;
		state == ST_PRECHARGE |-> precharge_mode && charge_on && status_line_a_oe
			&& status_line_b_oe;
	endproperty
	a_precharge_out: assert property (p_precharge_out) else $error("precharge outputs wrong"); // R3
	property p_precharge_timeout;
		state == ST_PRECHARGE && run_ok && sense_q.below_precharge_exit
			&& safety_cnt == TIMER_W'(PRECHARGE_LIMIT - 1) |=> state == ST_FAULT;
	endproperty
	a_precharge_timeout: assert property (p_precharge_timeout) else $error("no fault"); // R4
	// The pins may change again one cycle later, so only the next state is pinned down.
	property p_hiz_disable;
		pin_s_q.usb_rate_hiz && !pin_s_q.ac_present |=> !charge_on
			&& state inside {ST_SLEEP, ST_DISABLED};
	endproperty
	a_hiz_disable: assert property (p_hiz_disable) else $error("floating rate charged"); // R6
	property p_taper_reset;
		state == ST_REGULATE && run_ok && !sense_q.below_taper |=> taper_cnt == '0;
	endproperty
	a_taper_reset: assert property (p_taper_reset) else $error("taper timer kept"); // R10
	property p_cutoff;
		state == ST_REGULATE && run_ok && sense_q.below_cutoff |=> state == ST_DONE
			&& !charge_on;
	endproperty
	a_cutoff: assert property (p_cutoff) else $error("cutoff did not terminate"); // R11
	property p_recharge;
		state inside {ST_DONE, ST_FAULT} && run_ok && sense_q.below_recharge
			|=> state inside {ST_PRECHARGE, ST_FAST} && safety_cnt == '0;
	endproperty
	a_recharge: assert property (p_recharge) else $error("no new cycle"); // R12
	property p_sleep;
		!pin_s_q.ac_present && !pin_s_q.usb_present |=> state == ST_SLEEP
			&& !adapter_good_n_oe && !status_line_a_oe && !status_line_b_oe;
	endproperty
	a_sleep: assert property (p_sleep) else $error("sleep not entered"); // R13
	property p_fault_status;
		state == ST_FAULT |-> !status_line_a_oe && !status_line_b_oe && !charge_on;
	endproperty
	a_fault_status: assert property (p_fault_status) else $error("fault status wrong"); // R14
	property p_power_good;
		adapter_good_n_oe == ($past(pin_s_q.ac_present) && state != ST_SLEEP);
	endproperty
	a_power_good: assert property (p_power_good) else $error("power-good wrong"); // R15
	property p_ce_fall;
		ce_fall && source_ok && !ctrl_inhibit |=> safety_cnt == '0 && taper_cnt == '0
			&& state != ST_FAULT;
	endproperty
	a_ce_fall: assert property (p_ce_fall) else $error("timers not reset"); // R18
	c_fault: cover property (state == ST_FAST ##1 state == ST_FAULT);
	c_done: cover property (state == ST_REGULATE ##1 state == ST_DONE);
	c_recharge: cover property (state == ST_DONE ##1 state == ST_FAST);

endmodule : charge_sequence_controller

// File: sim/charger_far_side.sv
`timescale 1ns/1ns
module charger_far_side
	import charge_seq_pkg::*;
(
	input  wire logic       hclk,  // System clock.
	input  wire logic       ac,    // Adapter plugged in.
	input  wire logic       usb,   // USB port plugged in.
	input  wire logic       en_n,  // Host charge enable, active low.
	input  wire logic [1:0] rate,  // Host rate: 0 low, 1 high, 2 released.
	input  wire logic [1:0] batt,  // Battery: 0 deep, 1 low, 2 mid, 3 full.
	input  wire logic [1:0] cur,   // Current: 0 high, 1 under taper, 2 under cutoff.
	output pin_s            pins,  // Pin levels.
	output sense_s          sense  // Comparator levels.
);
	logic float_bit = 1'b0;

	// A released rate line has no pull, so its level must not be trusted.
	always @(posedge hclk) float_bit <= ~float_bit;

	always_comb begin
		pins.ac_present = ac;
		pins.usb_present = usb;
		pins.charge_enable_n = en_n;
		pins.usb_rate_select = (rate == 2'h2) ? float_bit : rate[0];
		pins.usb_rate_hiz = (rate == 2'h2);
		sense.below_precharge_exit = (batt == 2'h0);
		sense.at_regulation_voltage = (batt == 2'h3);
		sense.below_recharge = (batt < 2'h2);
		sense.below_taper = (cur != 2'h0);
		sense.below_cutoff = (cur == 2'h2);
	end
endmodule : charger_far_side

// File: sim/testbench.sv
`timescale 1ns/1ns
module testbench;
	import charge_seq_pkg::*;
	localparam longint PRE_LIM = 20;
	localparam longint FAST_LIM = 200;
	localparam longint TAP_LIM = 10;
	logic        hclk = 1'b0;
	logic        hresetn = 1'b0;
	logic        hsel = 1'b0;
	logic        hwrite = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [31:0] hwdata = 32'h0;
	logic [31:0] hrdata;
	logic [31:0] rd;
	logic [1:0]  htrans = 2'h0;
	logic [1:0]  hresp;
	logic [2:0]  hsize = 3'h2;
	logic        hreadyout;
	logic        ac = 1'b0;
	logic        usb = 1'b0;
	logic        en_n = 1'b0;
	logic [1:0]  rate = 2'h0;
	logic [1:0]  batt = 2'h0;
	logic [1:0]  cur = 2'h0;
	logic        charge_on, precharge_mode, usb_source, usb_high_rate;
	logic        a_out, a_oe, b_out, b_oe, pg_out, pg_oe;
	pin_s        pins;
	sense_s      sense;
	int          fail_count = 0;
	int          compares = 0;
	int          cycles = 0;
	int          n;

	initial forever #4 hclk = ~hclk;

	charger_far_side charger_far_side_inst (.hclk(hclk), .ac(ac), .usb(usb), .en_n(en_n),
		.rate(rate), .batt(batt), .cur(cur), .pins(pins), .sense(sense));

	charge_sequence_controller #(.PRECHARGE_LIMIT(PRE_LIM), .FAST_LIMIT(FAST_LIM),
		.TAPER_LIMIT(TAP_LIM)) charge_sequence_controller_inst (
		.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
		.hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .pins(pins), .sense(sense),
		.charge_on(charge_on), .precharge_mode(precharge_mode), .usb_source(usb_source),
		.usb_high_rate(usb_high_rate), .status_line_a_out(a_out), .status_line_a_oe(a_oe),
		.status_line_b_out(b_out), .status_line_b_oe(b_oe), .adapter_good_n_out(pg_out),
		.adapter_good_n_oe(pg_oe));

	////////////////////////////////////////////////////////////////
	task give_verdict;
		if (fail_count == 0 && compares > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : give_verdict

	task cmp(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			fail_count++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : cmp

	task ahb(input logic wr, input logic [31:0] a, input logic [31:0] wd);
		@(posedge hclk);
		hsel <= 1'b1;
		haddr <= a;
		htrans <= HTRANS_NONSEQ;
		hwrite <= wr;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		rd = hrdata;
		cmp({30'h0, hresp}, {30'h0, HRESP_OKAY});
	endtask : ahb

	// Each pin change needs three edges to reach the outputs, so the five that follow it are ample.
	task apply(input int a, input int u, input int e, input logic [1:0] r,
		input logic [1:0] b, input logic [1:0] c);
		@(posedge hclk);
		ac <= a[0];
		usb <= u[0];
		en_n <= e[0];
		rate <= r;
		batt <= b;
		cur <= c;
		repeat (5) @(posedge hclk);
	endtask : apply

	task expect_state(input charge_state_e st);
		logic [1:0] ab;
		logic       on;
		ab = (st == ST_PRECHARGE) ? 2'b11 : (st == ST_FAST || st == ST_REGULATE) ? 2'b10 :
			(st == ST_DONE) ? 2'b01 : 2'b00;
		on = (st == ST_PRECHARGE || st == ST_FAST || st == ST_REGULATE);
		ahb(1'b0, 32'h4, 32'h0);
		cmp({29'h0, rd[2:0]}, {29'h0, st});
		cmp({27'h0, rd[8:4]}, {27'h0, usb, ac, !ac && rate == 2'h1, on, !ac});
		cmp({27'h0, a_oe, b_oe, charge_on, precharge_mode, pg_oe},
			{27'h0, ab, on, st == ST_PRECHARGE, ac && st != ST_SLEEP});
		cmp({29'h0, a_out, b_out, pg_out}, 32'h0);
	endtask : expect_state

	////////////////////////////////////////////////////////////////
	always @(posedge hclk) begin
		cycles <= cycles + 1;
		if (cycles == 5000) begin
			fail_count++;
			give_verdict;
		end
	end

	initial begin
		repeat (10) @(posedge hclk);
		hresetn <= 1'b1;
		expect_state(ST_SLEEP);
		apply(1, 0, 0, 2'h0, 2'h0, 2'h0);
		expect_state(ST_PRECHARGE);
		cmp({31'h0, precharge_mode}, 32'h1);
		cmp({31'h0, usb_source}, 32'h0);
		n = 0;
		while (charge_on === 1'b1 && n < 100) begin
			@(posedge hclk);
			n++;
		end
		cmp({31'h0, n < 100}, 32'h1);
		cmp({30'h0, a_oe, b_oe}, 32'h0);
		repeat (3) @(posedge hclk);
		expect_state(ST_PRECHARGE);
		apply(1, 0, 0, 2'h0, 2'h2, 2'h0);
		expect_state(ST_FAST);
		repeat (FAST_LIM) @(posedge hclk);
		expect_state(ST_FAULT);
		apply(1, 0, 0, 2'h0, 2'h1, 2'h0);
		expect_state(ST_FAST);
		apply(1, 0, 0, 2'h0, 2'h3, 2'h0);
		expect_state(ST_REGULATE);
		apply(1, 0, 0, 2'h0, 2'h3, 2'h1);
		apply(1, 0, 0, 2'h0, 2'h3, 2'h0);
		apply(1, 0, 0, 2'h0, 2'h3, 2'h1);
		expect_state(ST_REGULATE);
		repeat (TAP_LIM) @(posedge hclk);
		expect_state(ST_DONE);
		apply(1, 0, 0, 2'h0, 2'h1, 2'h0);
		expect_state(ST_FAST);
		apply(1, 0, 0, 2'h0, 2'h3, 2'h0);
		apply(1, 0, 0, 2'h0, 2'h3, 2'h2);
		expect_state(ST_DONE);
		apply(1, 0, 1, 2'h0, 2'h0, 2'h0);
		expect_state(ST_DISABLED);
		apply(1, 0, 0, 2'h0, 2'h0, 2'h0);
		expect_state(ST_PRECHARGE);
		apply(0, 1, 0, 2'h1, 2'h2, 2'h0);
		expect_state(ST_FAST);
		cmp({30'h0, usb_source, usb_high_rate}, 32'h3);
		apply(0, 1, 0, 2'h0, 2'h2, 2'h0);
		cmp({30'h0, usb_source, usb_high_rate}, 32'h2);
		apply(0, 1, 0, 2'h2, 2'h2, 2'h0);
		expect_state(ST_DISABLED);
		apply(1, 1, 0, 2'h2, 2'h2, 2'h0);
		expect_state(ST_FAST);
		cmp({31'h0, usb_source}, 32'h0);
		ahb(1'b1, 32'h0, 32'h1);
		ahb(1'b0, 32'h0, 32'h0);
		cmp(rd, 32'h1);
		expect_state(ST_DISABLED);
		ahb(1'b1, 32'h0, 32'h0);
		ahb(1'b1, 32'h4, 32'h3);
		ahb(1'b0, 32'h8, 32'h0);
		cmp(rd, 32'h0);
		repeat (5) @(posedge hclk);
		expect_state(ST_FAST);
		apply(0, 0, 0, 2'h0, 2'h2, 2'h0);
		expect_state(ST_SLEEP);
		give_verdict;
	end
endmodule : testbench
